// ### pkg/frps_pkg.sv
// Purpose: shared constants, state codes and pulse sizing for the range program sequencer
// Assumes: every count is in bus cycles, one bus cycle per clock with ce high
// Notes: bus clock runs 1.0 to 8.0 MHz; the 250 MHz clk only carries the ce strobe
package frps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int ROW_BYTES = 32;
    localparam logic [15:0] ROW_MASK = 16'hFFE0;
    localparam logic [15:0] PAGE_MASK = 16'hFFC0;
    localparam logic [15:0] ONE_ADDR = 16'h0001;
    localparam logic [5:0] ONE_IDX = 6'h01;

    ////////////////////////////////////////////////////////////////////////
    // timing, times in their own unit, counts in bus cycles
    localparam int CLK_MHZ = 250;
    localparam int T_PROG_MIN_US = 30;
    localparam int T_PROG_MAX_US = 40;
    localparam int T_HV_BYTE_MAX_US = 125;
    localparam int T_HV_ROW_MAX_US = 4000;
    localparam int T_ERASE_MIN_US = 4000;
    localparam logic [5:0] SPD_MIN = 6'h04;
    localparam logic [5:0] SPD_MAX = 6'h20;
    localparam logic [15:0] PULSE_SLOW = 16'h0026;
    localparam logic [15:0] PULSE_ADD = 16'h0005;
    localparam logic [15:0] PULSE_MAX = 16'h0105;
    localparam logic [5:0] WD_FIRST = 6'h2A;
    localparam logic [1:0] HV_SETUP = 2'h2;
    localparam logic [1:0] HV_HOLD = 2'h2;
    // erase cycles per unit of speed value: T_ERASE_MIN_US / 4
    localparam int ERASE_UNITS_DEF = T_ERASE_MIN_US / 4;

    ////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [3:0] {
        FRPS_IDLE  = 4'h0,
        FRPS_PLAN  = 4'h1,
        FRPS_LOAD  = 4'h2,
        FRPS_LOADW = 4'h3,
        FRPS_RD    = 4'h4,
        FRPS_WR    = 4'h5,
        FRPS_SETUP = 4'h6,
        FRPS_PULSE = 4'h7,
        FRPS_HOLD  = 4'h8,
        FRPS_FIN   = 4'h9
    } frps_state_t;

    ////////////////////////////////////////////////////////////////////////
    // clamp the speed value into the supported span
    function automatic logic [5:0] frps_clamp(input logic [5:0] spd);
        if (spd < SPD_MIN) begin
            return SPD_MIN;
        end
        if (spd > SPD_MAX) begin
            return SPD_MAX;
        end
        return spd;
    endfunction : frps_clamp

    // program pulse length in bus cycles
    function automatic logic [15:0] frps_prog_cycles(input logic [5:0] spd);
        logic [5:0] s;
        s = frps_clamp(spd);
        if (s == SPD_MIN) begin
            return PULSE_SLOW;
        end
        return {7'h00, s, 3'h0} + PULSE_ADD;
    endfunction : frps_prog_cycles

endpackage : frps_pkg

// ### rtl/frps_stage_mem.sv
// Purpose: one-row staging memory for bytes fetched from the zero page
// Assumes: single write port, one read port with registered data
// Notes: read data follows the read index one active tick later
`timescale 1ns/1ps
module frps_stage_mem (
    input wire logic clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic ce, // bus-cycle enable
    input wire logic wr_en, // write strobe
    input wire logic [4:0] wr_idx, // write index
    input wire logic [7:0] wr_data, // write byte
    input wire logic [4:0] rd_idx, // read index
    output logic [7:0] rd_data // registered read byte
);

    logic [7:0] mem [0:frps_pkg::ROW_BYTES-1];
    logic [7:0] next_rd_data;

    ////////////////////////////////////////////////////////////////////////
    // read path next value
    always_comb begin
        next_rd_data = mem[rd_idx];
    end

    // storage is not reset; only the read register needs a defined value
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= next_rd_data;
            if (wr_en) begin
                mem[wr_idx] <= wr_data;
            end
        end
    end

endmodule : frps_stage_mem

// ### rtl/frps_pulse_timer.sv
// Purpose: down counter that holds a pulse for a loaded number of bus cycles
// Assumes: load value is at least one
// Notes: expire pulses in the tick that active falls
`timescale 1ns/1ps
module frps_pulse_timer (
    input wire logic clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic ce, // bus-cycle enable
    input wire logic load, // start a pulse
    input wire logic [15:0] cycles, // pulse length in bus cycles
    output logic active, // pulse level
    output logic expire // one tick at pulse end
);

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_active;
    logic next_expire;

    ////////////////////////////////////////////////////////////////////////
    // countdown
    always_comb begin
        next_cnt = cnt;
        next_active = active;
        next_expire = 1'b0;
        if (load) begin
            next_cnt = cycles;
            next_active = 1'b1;
        end else if (active) begin
            next_cnt = cnt - frps_pkg::ONE_ADDR;
            if (cnt == frps_pkg::ONE_ADDR) begin
                next_active = 1'b0;
                next_expire = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt <= 16'h0000;
            active <= 1'b0;
            expire <= 1'b0;
        end else if (ce) begin
            cnt <= next_cnt;
            active <= next_active;
            expire <= next_expire;
        end
    end

endmodule : frps_pulse_timer

// ### rtl/frps_top.sv
// Purpose: flash range program sequencer with byte and row methods, plus erase
// Assumes: ce marks one bus cycle; zp_rd_data is valid while zp_rd_en is high
// Notes: ranges crossing an xxFF to xx00 boundary in row method are not guarded
//
// Summary of operation
// - works at any bus rate 1 to 8 MHz
// - pulse stays within 30 to 40 us
// - pulse 38 cycles at 4, else 8s+5
// - byte method and row method both supported
// - watchdog enabled: every byte programmed singly
// - watchdog off, one row: row method
// - watchdog off, multi-row: singles until last row, then row
// - single-byte high voltage under 125 us
// - cumulative row high voltage under 4 ms
// - mask interrupts while busy, restore on return
// - service watchdog, first at 42 cycles
// - exit index is address after range
// - short ranges program only requested bytes
// - page erase 64 bytes, protect address mass
`timescale 1ns/1ps
module frps_top #(
    parameter logic [15:0] BLOCK_PROTECT_ADDR = 16'hFF00, // block_protect_register address
    parameter int ERASE_UNITS = frps_pkg::ERASE_UNITS_DEF // erase cycles per speed unit
) (
    input wire logic clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic ce, // bus-cycle enable, freezes all state when low
    input wire logic prog_start, // flash_range_program_routine call, one tick
    input wire logic erase_start, // erase call, one tick
    input wire logic [15:0] first_addr, // index pair on entry
    input wire logic [15:0] last_range_address, // last address of range
    input wire logic [5:0] speed_scale_value, // bus MHz times four
    input wire logic watchdog_disable_bit, // from first_config_register
    input wire logic int_mask_in, // interrupt mask on entry
    input wire logic [7:0] zp_base, // zero-page start of data buffer
    input wire logic [7:0] zp_rd_data, // zero-page read byte
    output logic zp_rd_en, // zero-page read request
    output logic [7:0] zp_rd_addr, // zero-page read address
    output logic [15:0] flash_addr, // flash target address
    output logic [7:0] flash_wdata, // flash latch byte
    output logic flash_latch_wr, // flash latch write, one tick
    output logic flash_row_mode, // row method in progress
    output logic flash_hv, // high programming voltage enable
    output logic flash_pulse, // program or erase pulse
    output logic flash_erase, // erase operation
    output logic flash_mass, // mass erase selected
    output logic wdog_service, // operating_watchdog service, one tick
    output logic int_mask, // interrupt mask
    output logic busy, // sequencer running
    output logic done, // completion, one tick
    output logic [15:0] index_out // index pair on exit
);

    frps_pkg::frps_state_t state;
    frps_pkg::frps_state_t next_state;
    logic [15:0] cur, first_q, last_q, next_cur, next_first_q, next_last_q;
    logic [5:0] spd, next_spd, len, next_len, k, next_k, bus_cnt, next_bus_cnt;
    logic wd_dis, next_wd_dis, wd_pend, next_wd_pend, entry_mask, next_entry_mask;
    logic [1:0] ph, next_ph;
    logic next_zp_rd_en, next_latch_wr, next_row_mode, next_hv, next_erase, next_mass;
    logic next_wdog, next_int_mask, next_busy, next_done;
    logic [7:0] next_zp_rd_addr, next_wdata, mem_rd_data;
    logic [15:0] next_flash_addr, next_index, t_cycles, erase_cycles, batch_end;
    logic t_load, t_expire, mem_we;

    ////////////////////////////////////////////////////////////////////////
    // staging row and pulse timer
    frps_stage_mem i_frps_stage_mem (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .wr_en(mem_we),
        .wr_idx(k[4:0]),
        .wr_data(zp_rd_data),
        .rd_idx(k[4:0]),
        .rd_data(mem_rd_data)
    );

    frps_pulse_timer i_frps_pulse_timer (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .load(t_load),
        .cycles(t_cycles),
        .active(flash_pulse),
        .expire(t_expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // erase length scales with the speed value, so it tracks the bus rate
    assign erase_cycles = 16'(16'(frps_pkg::frps_clamp(spd)) * 16'(ERASE_UNITS));
    assign t_cycles = flash_erase ? erase_cycles : frps_pkg::frps_prog_cycles(spd);
    assign batch_end = cur + {10'h000, len} - frps_pkg::ONE_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_first_q = first_q;
        next_last_q = last_q;
        next_spd = spd;
        next_len = len;
        next_k = k;
        next_bus_cnt = bus_cnt;
        next_wd_dis = wd_dis;
        next_wd_pend = wd_pend;
        next_entry_mask = entry_mask;
        next_ph = ph;
        next_zp_rd_en = 1'b0;
        next_zp_rd_addr = zp_rd_addr;
        next_flash_addr = flash_addr;
        next_wdata = flash_wdata;
        next_latch_wr = 1'b0;
        next_row_mode = flash_row_mode;
        next_hv = flash_hv;
        next_erase = flash_erase;
        next_mass = flash_mass;
        next_wdog = 1'b0;
        next_int_mask = int_mask;
        next_busy = busy;
        next_done = 1'b0;
        next_index = index_out;
        t_load = 1'b0;
        mem_we = 1'b0;
        // first watchdog service counted from the call tick
        if (busy && bus_cnt != frps_pkg::WD_FIRST) begin
            next_bus_cnt = bus_cnt + frps_pkg::ONE_IDX;
        end
        if (busy && wd_pend && bus_cnt == frps_pkg::WD_FIRST - frps_pkg::ONE_IDX) begin
            next_wdog = 1'b1;
            next_wd_pend = 1'b0;
        end
        unique case (state)
            frps_pkg::FRPS_IDLE: begin
                if (prog_start || erase_start) begin
                    next_busy = 1'b1;
                    next_int_mask = 1'b1;
                    next_entry_mask = int_mask_in;
                    next_cur = first_addr;
                    next_first_q = first_addr;
                    next_last_q = last_range_address;
                    next_spd = speed_scale_value;
                    next_wd_dis = watchdog_disable_bit;
                    next_wd_pend = !watchdog_disable_bit;
                    next_bus_cnt = 6'h00;
                    next_ph = 2'h0;
                end
                if (prog_start) begin
                    next_state = frps_pkg::FRPS_PLAN;
                end else if (erase_start) begin
                    // protect register address selects the whole array
                    next_erase = 1'b1;
                    next_mass = (first_addr == BLOCK_PROTECT_ADDR);
                    next_flash_addr = first_addr & frps_pkg::PAGE_MASK;
                    next_hv = 1'b1;
                    next_state = frps_pkg::FRPS_SETUP;
                end
            end
            frps_pkg::FRPS_PLAN: begin
                // row method only with the watchdog off and in the last row
                next_k = 6'h00;
                if (wd_dis && (cur & frps_pkg::ROW_MASK) == (last_q & frps_pkg::ROW_MASK)) begin
                    next_row_mode = 1'b1;
                    next_len = 6'(last_q - cur + frps_pkg::ONE_ADDR);
                end else begin
                    next_row_mode = 1'b0;
                    next_len = frps_pkg::ONE_IDX;
                end
                next_state = frps_pkg::FRPS_LOAD;
            end
            frps_pkg::FRPS_LOAD: begin
                // buffer byte offset equals target offset within the range
                next_zp_rd_en = 1'b1;
                next_zp_rd_addr = zp_base + 8'(cur + {10'h000, k} - first_q);
                next_state = frps_pkg::FRPS_LOADW;
            end
            frps_pkg::FRPS_LOADW: begin
                mem_we = 1'b1;
                if (k == len - frps_pkg::ONE_IDX) begin
                    next_k = 6'h00;
                    next_state = frps_pkg::FRPS_RD;
                end else begin
                    next_k = k + frps_pkg::ONE_IDX;
                    next_state = frps_pkg::FRPS_LOAD;
                end
            end
            frps_pkg::FRPS_RD: begin
                next_state = frps_pkg::FRPS_WR;
            end
            frps_pkg::FRPS_WR: begin
                next_latch_wr = 1'b1;
                next_wdata = mem_rd_data;
                next_flash_addr = cur + {10'h000, k};
                if (k == len - frps_pkg::ONE_IDX) begin
                    next_hv = 1'b1;
                    next_ph = 2'h0;
                    next_state = frps_pkg::FRPS_SETUP;
                end else begin
                    next_k = k + frps_pkg::ONE_IDX;
                    next_state = frps_pkg::FRPS_RD;
                end
            end
            frps_pkg::FRPS_SETUP: begin
                next_ph = ph + 2'h1;
                if (ph == frps_pkg::HV_SETUP - 2'h1) begin
                    t_load = 1'b1;
                    next_state = frps_pkg::FRPS_PULSE;
                end
            end
            frps_pkg::FRPS_PULSE: begin
                next_ph = 2'h0;
                if (t_expire) begin
                    next_state = frps_pkg::FRPS_HOLD;
                end
            end
            frps_pkg::FRPS_HOLD: begin
                // program voltage window is pulse plus setup and hold, well under 125 us
                next_ph = ph + 2'h1;
                if (ph == frps_pkg::HV_HOLD - 2'h1) begin
                    next_hv = 1'b0;
                    next_ph = 2'h0;
                    if (!wd_dis) begin
                        next_wdog = 1'b1;
                    end
                    if (flash_erase || batch_end == last_q) begin
                        next_cur = batch_end + frps_pkg::ONE_ADDR;
                        next_state = frps_pkg::FRPS_FIN;
                    end else begin
                        next_cur = batch_end + frps_pkg::ONE_ADDR;
                        next_state = frps_pkg::FRPS_PLAN;
                    end
                end
            end
            frps_pkg::FRPS_FIN: begin
                // high voltage fell one tick earlier
                next_done = 1'b1;
                next_busy = 1'b0;
                next_int_mask = entry_mask;
                if (!flash_erase) begin
                    next_index = cur;
                end
                next_erase = 1'b0;
                next_mass = 1'b0;
                next_row_mode = 1'b0;
                next_state = frps_pkg::FRPS_IDLE;
            end
            default: begin
                next_state = frps_pkg::FRPS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers, advanced once per bus cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= frps_pkg::FRPS_IDLE;
            cur <= 16'h0000;
            first_q <= 16'h0000;
            last_q <= 16'h0000;
            spd <= frps_pkg::SPD_MIN;
            len <= 6'h00;
            k <= 6'h00;
            bus_cnt <= 6'h00;
            wd_dis <= 1'b0;
            wd_pend <= 1'b0;
            entry_mask <= 1'b0;
            ph <= 2'h0;
            zp_rd_en <= 1'b0;
            zp_rd_addr <= 8'h00;
            flash_addr <= 16'h0000;
            flash_wdata <= 8'h00;
            flash_latch_wr <= 1'b0;
            flash_row_mode <= 1'b0;
            flash_hv <= 1'b0;
            flash_erase <= 1'b0;
            flash_mass <= 1'b0;
            wdog_service <= 1'b0;
            int_mask <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            index_out <= 16'h0000;
        end else if (ce) begin
            state <= next_state;
            cur <= next_cur;
            first_q <= next_first_q;
            last_q <= next_last_q;
            spd <= next_spd;
            len <= next_len;
            k <= next_k;
            bus_cnt <= next_bus_cnt;
            wd_dis <= next_wd_dis;
            wd_pend <= next_wd_pend;
            entry_mask <= next_entry_mask;
            ph <= next_ph;
            zp_rd_en <= next_zp_rd_en;
            zp_rd_addr <= next_zp_rd_addr;
            flash_addr <= next_flash_addr;
            flash_wdata <= next_wdata;
            flash_latch_wr <= next_latch_wr;
            flash_row_mode <= next_row_mode;
            flash_hv <= next_hv;
            flash_erase <= next_erase;
            flash_mass <= next_mass;
            wdog_service <= next_wdog;
            int_mask <= next_int_mask;
            busy <= next_busy;
            done <= next_done;
            index_out <= next_index;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checking helpers: pulse and voltage lengths, ticks since the call
    logic [15:0] plen, hvlen;
    logic [5:0] wtick;
    logic wseen;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            plen <= 16'h0000;
            hvlen <= 16'h0000;
            wtick <= 6'h00;
            wseen <= 1'b0;
        end else if (ce) begin
            plen <= flash_pulse ? plen + frps_pkg::ONE_ADDR : 16'h0000;
            hvlen <= flash_hv ? hvlen + frps_pkg::ONE_ADDR : 16'h0000;
            if (state == frps_pkg::FRPS_IDLE) begin
                wtick <= 6'h00;
                wseen <= 1'b0;
            end else begin
                wtick <= (wtick == 6'h3F) ? wtick : wtick + frps_pkg::ONE_IDX;
                wseen <= wseen | wdog_service;
            end
        end
    end

    pulse_length_a: assert property (@(posedge clk) disable iff (!resetn)
        ($fell(flash_pulse) && !flash_erase) |-> plen == frps_pkg::frps_prog_cycles(spd))
        else $error("program pulse length wrong");
    hv_window_a: assert property (@(posedge clk) disable iff (!resetn)
        (flash_hv && !flash_erase) |-> hvlen <= frps_pkg::PULSE_MAX + 16'h0006)
        else $error("high voltage window too long");
    pulse_in_hv_a: assert property (@(posedge clk) disable iff (!resetn)
        flash_pulse |-> flash_hv)
        else $error("pulse outside high voltage");
    mask_busy_a: assert property (@(posedge clk) disable iff (!resetn)
        busy |-> int_mask)
        else $error("mask low while busy");
    mask_restore_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(done) |-> int_mask == entry_mask && !busy)
        else $error("mask not restored");
    done_hv_off_a: assert property (@(posedge clk) disable iff (!resetn)
        done |-> !flash_hv && !flash_pulse && $past(!flash_hv, 1))
        else $error("done with voltage on");
    exit_index_a: assert property (@(posedge clk) disable iff (!resetn)
        (done && !$past(flash_erase, 1)) |-> index_out == last_q + frps_pkg::ONE_ADDR)
        else $error("exit index wrong");
    wd_first_a: assert property (@(posedge clk) disable iff (!resetn)
        (wdog_service && !wseen) |-> wtick == frps_pkg::WD_FIRST && !wd_dis)
        else $error("first watchdog service misplaced");
    row_needs_wd_off_a: assert property (@(posedge clk) disable iff (!resetn)
        flash_row_mode |-> wd_dis)
        else $error("row method with watchdog on");
    single_before_row_a: assert property (@(posedge clk) disable iff (!resetn)
        (flash_latch_wr && !flash_row_mode && wd_dis) |->
        (flash_addr & frps_pkg::ROW_MASK) != (last_q & frps_pkg::ROW_MASK))
        else $error("single byte inside last row");
    addr_in_range_a: assert property (@(posedge clk) disable iff (!resetn)
        flash_latch_wr |-> flash_addr >= first_q && flash_addr <= last_q)
        else $error("latch write outside range");

endmodule : frps_top

// ### verification/frps_zp_model.sv
// Purpose: zero-page data buffer answering the sequencer's reads
// Assumes: combinational read, valid while the read request is high
// Notes: off-request the bus shows the inverse byte, so stale data never looks valid
`timescale 1ns/1ps
module frps_zp_model (
    input wire logic [7:0] rd_addr, // zero-page address
    input wire logic rd_en, // read request
    output logic [7:0] rd_data // byte returned
);
    // each buffer byte is a fixed function of its zero-page address
    always_comb begin
        rd_data = rd_en ? (rd_addr ^ 8'h5A) : ~(rd_addr ^ 8'h5A);
    end
endmodule : frps_zp_model

// ### verification/flash_range_program_sequencer_tb_top.sv
// Purpose: self-checking bench for the range program sequencer
// Assumes: ce held high, so every clk edge is one bus cycle
// Notes: erases come first; pulse length is judged on the last pulse of a call
`timescale 1ns/1ps
module flash_range_program_sequencer_tb_top;
    logic clk = 1'b0, resetn = 1'b0, start = 1'b0, wd = 1'b0, im = 1'b0, pp = 1'b0, er = 1'b0;
    logic [15:0] fa = 16'h0000, la = 16'h0000, flash_addr, index_out;
    logic [5:0] spd = 6'h04;
    logic [7:0] zp_rd_addr, zp_rd_data, flash_wdata;
    logic zp_rd_en, flash_latch_wr, flash_pulse, flash_hv, wdog_service, int_mask, busy, done;
    logic rm, fe, fm;
    int errors = 0, n_compared = 0, t = 0, plen = 0, npul = 0, nlat = 0, wfirst = 0;
    ////////////////////////////////////////////////////////////
    always #2 clk = ~clk;
    frps_zp_model i_frps_zp_model (.rd_addr(zp_rd_addr), .rd_en(zp_rd_en), .rd_data(zp_rd_data));
    // short erase units keep the erase pulse to a few ticks
    frps_top #(.BLOCK_PROTECT_ADDR(16'hFF00), .ERASE_UNITS(2)) i_frps_top (.clk(clk),
        .resetn(resetn), .ce(1'b1), .prog_start(start),
        .erase_start(er), .first_addr(fa), .last_range_address(la), .speed_scale_value(spd),
        .watchdog_disable_bit(wd), .int_mask_in(im), .zp_base(8'h4C), .zp_rd_data(zp_rd_data),
        .zp_rd_en(zp_rd_en), .zp_rd_addr(zp_rd_addr), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_latch_wr(flash_latch_wr), .flash_row_mode(rm),
        .flash_hv(flash_hv), .flash_pulse(flash_pulse), .flash_erase(fe), .flash_mass(fm),
        .wdog_service(wdog_service), .int_mask(int_mask), .busy(busy), .done(done),
        .index_out(index_out));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // per-call counters, cleared on the call tick; ticks counted from the call
    always @(posedge clk) begin
        t = (start || er) ? 0 : t + 1;
        if (start || er) {npul, nlat, wfirst} = 96'h0;
        if (flash_pulse && !pp) npul++;
        if (flash_pulse && !pp) plen = 0;
        plen = plen + flash_pulse;
        pp = flash_pulse;
        if (wdog_service && wfirst == 0) wfirst = t;
        if (busy === 1'b1) chk(int_mask, 16'h0001);
        if (flash_latch_wr === 1'b1) begin
            nlat++;
            chk(flash_wdata, 8'(8'h4C + 8'(flash_addr - fa)) ^ 8'h5A);
            chk(16'(flash_addr >= fa && flash_addr <= la), 16'h0001);
            chk(16'(rm), 16'(wd && (flash_addr & 16'hFFE0) == (la & 16'hFFE0)));
        end
    end
    // one call, then judge the exit state; np pulses of pl ticks expected
    task automatic run(input logic [15:0] f, input logic [15:0] l, input logic [5:0] s,
            input logic w, input int np, input int pl);
        int k;
        k = 0;
        @(posedge clk);
        fa <= f;
        la <= l;
        spd <= s;
        wd <= w;
        im <= ~im;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        while (done !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        chk(16'(done), 16'h0001);
        chk(flash_hv, 16'h0000);
        chk(int_mask, im);
        chk(index_out, l + 16'h0001);
        chk(16'(npul), 16'(np));
        chk(16'(plen), 16'(pl));
        chk(16'(nlat), l - f + 16'h0001);
        chk(16'(wfirst), w ? 16'h0000 : 16'h002B);
    endtask : run
    // erase call; watchdog off so its early service after a short pulse is not judged
    task automatic erase(input logic [15:0] a, input logic [5:0] s, input logic m,
            input int pl);
        int k;
        logic [15:0] ix;
        k = 0;
        ix = index_out;
        @(posedge clk);
        fa <= a;
        spd <= s;
        wd <= 1'b1;
        im <= ~im;
        er <= 1'b1;
        @(posedge clk);
        er <= 1'b0;
        @(negedge clk);
        chk(16'(fe), 16'h0001);
        chk(16'(fm), 16'(m));
        chk(flash_addr, a & 16'hFFC0);
        while (done !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        chk(16'(done), 16'h0001);
        chk(flash_hv, 16'h0000);
        chk(int_mask, im);
        chk(index_out, ix);
        chk(16'(npul), 16'h0001);
        chk(16'(plen), 16'(pl));
    endtask : erase
    task automatic byte_slow_wd();
        run(16'hC000, 16'hC000, 6'h04, 1'b0, 1, 38);
    endtask : byte_slow_wd
    task automatic row_fast();
        run(16'hC000, 16'hC01F, 6'h20, 1'b1, 1, 261);
    endtask : row_fast
    task automatic pair_in_row();
        run(16'hE004, 16'hE005, 6'h18, 1'b1, 1, 197);
    endtask : pair_in_row
    task automatic multi_row();
        run(16'hC01E, 16'hC021, 6'h0A, 1'b1, 3, 85);
    endtask : multi_row
    task automatic cross_row_wd();
        run(16'hC01E, 16'hC021, 6'h05, 1'b0, 4, 45);
    endtask : cross_row_wd
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        erase(16'hC010, 6'h04, 1'b0, 8);
        erase(16'hFF00, 6'h08, 1'b1, 16);
        byte_slow_wd();
        row_fast();
        pair_in_row();
        multi_row();
        cross_row_wd();
        stop_test();
    end
    // hang guard, far beyond the roughly twelve hundred ticks the calls need
    initial begin
        #80000;
        errors++;
        stop_test();
    end
endmodule : flash_range_program_sequencer_tb_top
